// [hsmp_pkg.sv]
/*
  hsmp_pkg: constants shared by both ends of the host serial message port.
  Assumes a 100 MHz system clock on both ends.
*/
package hsmp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 10000;
  localparam int SCLK_MIN_PERIOD_PS = 125000;
  localparam int SCLK_HALF_CYC      =
    (SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SEL_GAP_NS         = 400;
  localparam int SEL_GAP_CYC        =
    (SEL_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam int MEM_WORDS = 64;
  localparam int BUF_WORDS = 32;
  localparam int CNT_W     = 12;
  localparam logic [11:0] HDR_BITS  = 12'h018;
  localparam logic [11:0] STAT_BITS = 12'h010;
  localparam logic [11:0] PEER_BITS = 12'h008;
  localparam logic [11:0] WORD_BITS = 12'h020;
  localparam int STAT_TXQ   = 1;
  localparam int STAT_RX_BUFFER_READY_FLAG = 0;
  // ---------------------------------------------------------------
  // registers (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [9:0] REG_CTRL   = 10'h000;
  localparam logic [9:0] REG_TXCMD  = 10'h004;
  localparam logic [9:0] REG_RXCMD  = 10'h008;
  localparam logic [9:0] REG_STATUS = 10'h00C;
  localparam logic [1:0] MEM_PAGE   = 2'h1;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CTRL_EDGE    = 0;
  localparam int CTRL_DONE_IE = 1;
  localparam int CTRL_RX_IE   = 2;
  localparam int CMD_BUF      = 8;
  localparam int RXCMD_EN     = 0;
  localparam int ST_TXQ       = 0;
  localparam int ST_RX_BUFFER_READY_FLAG     = 1;
  localparam int ST_DONE      = 2;
  localparam int ST_RXARR     = 3;
  localparam int ST_RXLEN     = 8;
  // ---------------------------------------------------------------
  // master states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    M_IDLE  = 4'b0001,
    M_SETUP = 4'b0010,
    M_XFER  = 4'b0100,
    M_GAP   = 4'b1000
  } hsmp_mstate_type;
endpackage

// [hsmp_if.sv]
/*
  hsmp_if: serial link between the message port and its host master.
  Assumes the bench resolves host_serial_out from its enable.
*/
`timescale 1ns/1ps
interface hsmp_if;
  logic host_serial_clock;
  logic host_slave_select_n;
  logic host_serial_in;
  logic host_serial_out;
  logic host_serial_out_oe;
  logic host_attention;
  modport device (
    input  host_serial_clock,
    input  host_slave_select_n,
    input  host_serial_in,
    output host_serial_out,
    output host_serial_out_oe,
    output host_attention
  );
  modport host (
    output host_serial_clock,
    output host_slave_select_n,
    output host_serial_in,
    input  host_serial_out,
    input  host_serial_out_oe,
    input  host_attention
  );
endinterface

// [hsmp_device.sv]
/*
  hsmp_device: serial slave message port with 64-word buffer memory.
  Assumes link pins are asynchronous; software on classic Wishbone.
*/
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - slave, selectable edge, msb first
// - output released while select inactive
// - serial clock at most 8 MHz
// - select low starts frame, high ends
// - master sends status then zero pad
// - device sends pad then status
// - status: bit1 queued, bit0 ready
// - one length byte in words
// - master may stop after status
// - buffers move from lowest address
// - master clocks longer payload fully
// - select high at least 400 ns
// - first word zeros then N-1
// - 64-word memory moved without software
// - queued send raises attention line
// - attention drops in frame, returns if unsent
// - maskable frame-done interrupt and flag
// - ready only after enable; arrival flag
// - attention after refused send once ready
// - distinct buffers for both directions
// - master writes only on ready
// - master reads only on queued
module hsmp_device
  import hsmp_pkg::*;
#(
  parameter int MEM_DEPTH = MEM_WORDS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial link
  hsmp_if.device           link,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o
);
  localparam int AW = $clog2(MEM_DEPTH);

  logic [31:0]      mem [MEM_DEPTH];
  logic [2:0]       sclk_q;
  logic [1:0]       sel_q;
  logic [1:0]       din_q;
  logic             sel_d;
  logic             in_frame;
  logic             frame_start;
  logic             frame_end;
  logic             sample_ev;
  logic             change_ev;
  logic [2:0]       ctrl;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] pay;
  logic [CNT_W-1:0] next_pay;
  logic [31:0]      rx_sh;
  logic [31:0]      rx_word;
  logic [31:0]      tx_sh;
  logic [7:0]       peer_status;
  logic [7:0]       rx_len;
  logic [7:0]       len_out;
  logic             tx_sending;
  logic             rx_take;
  logic             tx_queued;
  logic             tx_buf;
  logic [7:0]       tx_len;
  logic             rx_ready;
  logic             rx_buf;
  logic             refused;
  logic             done_flag;
  logic             rx_arrived;
  logic [7:0]       rx_count;
  logic             serial_we;
  logic [AW-1:0]    rx_addr;
  logic [AW-1:0]    tx_addr;
  logic             wb_go;
  logic             mem_hit;
  logic             wr_tx;
  logic             wr_rx;
  logic             wr_st;
  logic             oe;
  logic             att;

  // ---------------------------------------------------------------
  // link synchronisers and frame events
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      sel_q  <= 2'h3;
      din_q  <= 2'h0;
      sel_d  <= 1'b1;
    end else begin
      sclk_q <= {sclk_q[1:0], link.host_serial_clock};
      sel_q  <= {sel_q[0], link.host_slave_select_n};
      din_q  <= {din_q[0], link.host_serial_in};
      sel_d  <= sel_q[1];
    end
  end

  assign in_frame    = ~sel_q[1];
  assign frame_start = sel_d & ~sel_q[1];
  assign frame_end   = ~sel_d & sel_q[1];
  assign sample_ev   = in_frame & (ctrl[CTRL_EDGE] ?
                       (~sclk_q[1] & sclk_q[2]) : (sclk_q[1] & ~sclk_q[2]));
  assign change_ev   = in_frame & (ctrl[CTRL_EDGE] ?
                       (sclk_q[1] & ~sclk_q[2]) : (~sclk_q[1] & sclk_q[2]));

  // ---------------------------------------------------------------
  // receive shifter and memory writes
  // ---------------------------------------------------------------
  assign next_cnt  = bit_cnt + 12'h001;
  assign pay       = bit_cnt - HDR_BITS;
  assign next_pay  = next_cnt - HDR_BITS;
  assign rx_word   = {rx_sh[30:0], din_q[1]};
  assign rx_addr   = AW'({rx_buf, 5'h00}) + AW'(next_pay[11:5] - 7'h01);
  assign tx_addr   = AW'({tx_buf, 5'h00}) + AW'(pay[11:5]);
  assign serial_we = sample_ev & rx_take & (next_cnt >= HDR_BITS + WORD_BITS)
                     & (next_pay[4:0] == 5'h00)
                     & ({1'b0, next_pay[11:5]} <= {1'b0, rx_len});

  always_ff @(posedge clk_i) begin
    if (rst_i || frame_start) begin
      bit_cnt <= '0;
    end else if (sample_ev) begin
      bit_cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh       <= 32'h0;
      peer_status <= 8'h00;
      rx_len      <= 8'h00;
    end else if (frame_start) begin
      peer_status <= 8'h00;
      rx_len      <= 8'h00;
    end else if (sample_ev) begin
      rx_sh <= rx_word;
      if (next_cnt == PEER_BITS) begin
        peer_status <= rx_word[7:0];
      end
      if (next_cnt == HDR_BITS) begin
        rx_len <= rx_word[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // buffer memory
  // ---------------------------------------------------------------
  assign wb_go   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~serial_we;
  assign mem_hit = (wb_adr_i[9:8] == MEM_PAGE);

  always_ff @(posedge clk_i) begin
    if (serial_we) begin
      mem[rx_addr] <= rx_word;
    end else if (wb_go && wb_we_i && mem_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          mem[wb_adr_i[AW+1:2]][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit shifter
  // ---------------------------------------------------------------
  assign len_out = (tx_queued && peer_status[STAT_RX_BUFFER_READY_FLAG]) ? tx_len : 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh      <= 32'h0;
      tx_sending <= 1'b0;
      rx_take    <= 1'b0;
    end else if (frame_start) begin
      tx_sh      <= {8'h00, 6'h00, tx_queued, rx_ready, 16'h0000};
      tx_sending <= 1'b0;
      rx_take    <= rx_ready;
    end else if (change_ev && bit_cnt != '0) begin
      if (bit_cnt == STAT_BITS) begin
        tx_sh[31:24] <= len_out;
        tx_sending   <= (len_out != 8'h00);
      end else if (bit_cnt >= HDR_BITS && pay[4:0] == 5'h00) begin
        tx_sh <= (tx_sending && {1'b0, pay[11:5]} < {1'b0, tx_len}) ?
                 mem[tx_addr] : 32'h0;
      end else begin
        tx_sh <= {tx_sh[30:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // message state and flags
  // ---------------------------------------------------------------
  assign wr_tx = wb_go & wb_we_i & (wb_adr_i == REG_TXCMD);
  assign wr_rx = wb_go & wb_we_i & (wb_adr_i == REG_RXCMD);
  assign wr_st = wb_go & wb_we_i & (wb_adr_i == REG_STATUS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_queued <= 1'b0;
      tx_buf    <= 1'b0;
      tx_len    <= 8'h00;
    end else if (frame_end && tx_sending &&
                 bit_cnt >= HDR_BITS + {tx_len[6:0], 5'h00}) begin
      tx_queued <= 1'b0;
    end else if (wr_tx && !tx_queued && !in_frame) begin
      tx_queued <= 1'b1;
      tx_buf    <= wb_dat_i[CMD_BUF];
      tx_len    <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ready   <= 1'b0;
      rx_buf     <= 1'b0;
      rx_arrived <= 1'b0;
      rx_count   <= 8'h00;
      refused    <= 1'b0;
    end else begin
      if (frame_end && rx_take && rx_len != 8'h00 &&
          bit_cnt >= HDR_BITS + {rx_len[6:0], 5'h00}) begin
        rx_ready   <= 1'b0;
        rx_arrived <= 1'b1;
        rx_count   <= rx_len;
      end else begin
        if (wr_rx && !in_frame) begin
          rx_ready <= wb_dat_i[RXCMD_EN];
          rx_buf   <= wb_dat_i[CMD_BUF];
        end
        if (wr_st && wb_dat_i[ST_RXARR]) begin
          rx_arrived <= 1'b0;
        end
      end
      if (frame_end && !rx_take && peer_status[STAT_TXQ]) begin
        refused <= 1'b1;
      end else if (frame_start && rx_ready) begin
        refused <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
    end else if (frame_end && bit_cnt != '0) begin
      done_flag <= 1'b1;
    end else if (wr_st && wb_dat_i[ST_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pins and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe    <= 1'b0;
      att   <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      oe    <= in_frame;
      att   <= ~in_frame & (tx_queued | (rx_ready & refused));
      irq_o <= (done_flag & ctrl[CTRL_DONE_IE])
             | (rx_arrived & ctrl[CTRL_RX_IE]);
    end
  end

  assign link.host_serial_out    = tx_sh[31];
  assign link.host_serial_out_oe = oe;
  assign link.host_attention     = att;

  // ---------------------------------------------------------------
  // wishbone registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (wb_go && wb_we_i && wb_adr_i == REG_CTRL) begin
      ctrl <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_go;
      if (wb_go && !wb_we_i) begin
        if (mem_hit) begin
          wb_dat_o <= mem[wb_adr_i[AW+1:2]];
        end else begin
          case (wb_adr_i)
            REG_CTRL:   wb_dat_o <= {29'h0, ctrl};
            REG_TXCMD:  wb_dat_o <= {23'h0, tx_buf, tx_len};
            REG_RXCMD:  wb_dat_o <= {23'h0, rx_buf, 7'h00, rx_ready};
            REG_STATUS: wb_dat_o <= {16'h0, rx_count, 4'h0, rx_arrived,
                                     done_flag, rx_ready, tx_queued};
            default:    wb_dat_o <= 32'h0;
          endcase
        end
      end
    end
  end

endmodule // hsmp_device

// [hsmp_master.sv]
/*
  hsmp_master: host-side master that runs one message transaction.
  Assumes the device samples on rising edges (edge select clear).
*/
`timescale 1ns/1ps
module hsmp_master
  import hsmp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int GAP_CYC  = SEL_GAP_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial link
  hsmp_if.host             link,
  // user request
  input  wire logic        start_i,
  input  wire logic [7:0]  tx_len_i,
  input  wire logic        rx_ready_i,
  input  wire logic [31:0] tx_word_i,
  // user answer
  output logic             busy_o,
  output logic             done_o,
  output logic             tx_word_rd_o,
  output logic [31:0]      rx_word_o,
  output logic             rx_word_valid_o,
  output logic [7:0]       dev_status_o,
  output logic [7:0]       dev_len_o,
  output logic             attention_o
);
  hsmp_mstate_type  state;
  logic [1:0]       miso_q;
  logic [1:0]       att_q;
  logic [7:0]       div;
  logic             sclk;
  logic             sel_n;
  logic [31:0]      sh_out;
  logic [31:0]      sh_in;
  logic [31:0]      in_word;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] pay;
  logic [CNT_W-1:0] next_pay;
  logic [CNT_W-1:0] total;
  logic [7:0]       my_len;
  logic [7:0]       my_eff;
  logic             my_rx;
  logic             dev_send;
  logic             half_done;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_q      <= 2'h0;
      att_q       <= 2'h0;
      attention_o <= 1'b0;
    end else begin
      miso_q      <= {miso_q[0], link.host_serial_out};
      att_q       <= {att_q[0], link.host_attention};
      attention_o <= att_q[1];
    end
  end

  assign next_cnt  = cnt + 12'h001;
  assign pay       = cnt - HDR_BITS;
  assign next_pay  = next_cnt - HDR_BITS;
  assign in_word   = {sh_in[30:0], miso_q[1]};
  assign half_done = (div == 8'(HALF_CYC - 1));

  // ---------------------------------------------------------------
  // transaction engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= M_IDLE;
      div             <= 8'h00;
      sclk            <= 1'b0;
      sel_n           <= 1'b1;
      sh_out          <= 32'h0;
      sh_in           <= 32'h0;
      cnt             <= '0;
      total           <= '0;
      my_len          <= 8'h00;
      my_eff          <= 8'h00;
      my_rx           <= 1'b0;
      dev_send        <= 1'b0;
      busy_o          <= 1'b0;
      done_o          <= 1'b0;
      tx_word_rd_o    <= 1'b0;
      rx_word_o       <= 32'h0;
      rx_word_valid_o <= 1'b0;
      dev_status_o    <= 8'h00;
      dev_len_o       <= 8'h00;
    end else begin
      done_o          <= 1'b0;
      tx_word_rd_o    <= 1'b0;
      rx_word_valid_o <= 1'b0;
      case (state)
        M_IDLE: begin
          if (start_i) begin
            my_len <= tx_len_i;
            my_rx  <= rx_ready_i;
            dev_len_o <= 8'h00;
            sh_out <= {6'h00, tx_len_i != 8'h00, rx_ready_i, 24'h0};
            sel_n  <= 1'b0;
            cnt    <= '0;
            div    <= 8'h00;
            busy_o <= 1'b1;
            state  <= M_SETUP;
          end
        end
        M_SETUP: begin
          div <= half_done ? 8'h00 : div + 8'h01;
          if (half_done) begin
            state <= M_XFER;
          end
        end
        M_XFER: begin
          div <= half_done ? 8'h00 : div + 8'h01;
          if (half_done && !sclk) begin
            sclk  <= 1'b1;
            sh_in <= in_word;
            cnt   <= next_cnt;
            if (next_cnt == STAT_BITS) begin
              dev_status_o <= in_word[7:0];
              dev_send     <= my_rx & in_word[STAT_TXQ];
            end
            if (next_cnt == HDR_BITS) begin
              dev_len_o <= dev_send ? in_word[7:0] : 8'h00;
              total     <= HDR_BITS + {((dev_send &&
                           in_word[7:0] > my_eff) ? in_word[6:0] :
                           my_eff[6:0]), 5'h00};
            end
            if (next_cnt >= HDR_BITS + WORD_BITS && next_pay[4:0] == 5'h00
                && dev_send && {1'b0, next_pay[11:5]} <= {1'b0, dev_len_o}) begin
              rx_word_o       <= in_word;
              rx_word_valid_o <= 1'b1;
            end
          end else if (half_done) begin
            sclk <= 1'b0;
            if ((cnt == STAT_BITS && !(my_len != 8'h00 &&
                 dev_status_o[STAT_RX_BUFFER_READY_FLAG]) && !dev_send) ||
                (cnt >= HDR_BITS && cnt == total)) begin
              sel_n  <= 1'b1;
              done_o <= 1'b1;
              div    <= 8'h00;
              state  <= M_GAP;
            end else if (cnt == STAT_BITS) begin
              my_eff <= dev_status_o[STAT_RX_BUFFER_READY_FLAG] ? my_len : 8'h00;
              sh_out <= {(dev_status_o[STAT_RX_BUFFER_READY_FLAG] ? my_len : 8'h00),
                         24'h0};
            end else if (cnt >= HDR_BITS && pay[4:0] == 5'h00) begin
              if ({1'b0, pay[11:5]} < {1'b0, my_eff}) begin
                sh_out       <= tx_word_i;
                tx_word_rd_o <= 1'b1;
              end else begin
                sh_out <= 32'h0;
              end
            end else begin
              sh_out <= {sh_out[30:0], 1'b0};
            end
          end
        end
        M_GAP: begin
          div <= div + 8'h01;
          if (div == 8'(GAP_CYC - 1)) begin
            busy_o <= 1'b0;
            state  <= M_IDLE;
          end
        end
        default: begin
          state <= M_IDLE;
        end
      endcase
    end
  end

  assign link.host_serial_clock   = sclk;
  assign link.host_slave_select_n = sel_n;
  assign link.host_serial_in      = sh_out[31];

endmodule // hsmp_master

// [hsmp_checker.sv]
/*
  hsmp_checker: link assertions for the message port.
  Assumes instantiation beside the interface, connected by name.
*/
`timescale 1ns/1ps
module hsmp_checker
  import hsmp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic host_serial_clock,
  input wire logic host_slave_select_n,
  input wire logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic host_serial_out_oe,
  input wire logic host_attention
);
  // ---------------------------------------------------------------
  // select gap counter
  // ---------------------------------------------------------------
  logic [5:0] gap_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_cnt <= 6'h28;
    end else if (!host_slave_select_n) begin
      gap_cnt <= 6'h00;
    end else if (gap_cnt != 6'h3F) begin
      gap_cnt <= gap_cnt + 6'h01;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_OE_OFF: assert property (
    host_slave_select_n [*4] |-> !host_serial_out_oe)
    else $error("serial out driven while deselected");
  AST_OE_ON: assert property (
    !host_slave_select_n [*4] |-> host_serial_out_oe)
    else $error("serial out not driven in frame");
  AST_ATTN_FRAME: assert property (
    !host_slave_select_n [*4] |-> !host_attention)
    else $error("attention high in frame");
  AST_SCLK_HIGH: assert property (
    $rose(host_serial_clock) |-> host_serial_clock [*6])
    else $error("serial clock high phase short");
  AST_SCLK_LOW: assert property (
    $fell(host_serial_clock) |-> !host_serial_clock [*6])
    else $error("serial clock low phase short");
  AST_SEL_GAP: assert property (
    $fell(host_slave_select_n) |-> gap_cnt >= 6'h28)
    else $error("select gap too short");
  AST_DIN_HOLD: assert property (
    $rose(host_serial_clock) |-> $stable(host_serial_in) [*6])
    else $error("serial in moved near sample edge");
  AST_DOUT_HOLD: assert property (
    $rose(host_serial_clock) && !host_slave_select_n
      |-> $stable(host_serial_out) [*3])
    else $error("serial out moved near sample edge");
endmodule // hsmp_checker

// [test_host_spi_slave_message_port.sv]
/*
  test_host_spi_slave_message_port: device and master on one link.
  Assumes default master timing; software over wishbone calls.
*/
`timescale 1ns/1ps
module test_host_spi_slave_message_port
  import hsmp_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [9:0]  adr   = 10'h000;
  logic [31:0] wdat  = 32'h00000000;
  logic        start = 1'b0;
  logic [7:0]  len   = 8'h00;
  logic        rdy   = 1'b0;
  logic [31:0] mw [2] = '{32'h00000001, 32'hC3C33C3C};
  logic [31:0] rw [2];
  logic [1:0]  ti    = 2'h0;
  logic [1:0]  ri    = 2'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic [31:0] rword;
  logic [7:0]  dst;
  logic [7:0]  dln;
  logic        ack;
  logic        irq;
  logic        busy;
  logic        done;
  logic        trd;
  logic        rv;
  logic        attn;
  int          n_errors = 0;
  int          n_checks = 0;
  hsmp_if link_a ();
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (trd) ti <= ti + 2'h1;
    if (rv) begin
      rw[ri[0]] <= rword;
      ri <= ri + 2'h1;
    end
  end
  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  hsmp_device hsmp_device_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_a.device), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq));
  hsmp_master hsmp_master_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(link_a.host), .start_i(start), .tx_len_i(len),
    .rx_ready_i(rdy), .tx_word_i(mw[ti[0]]), .busy_o(busy),
    .done_o(done), .tx_word_rd_o(trd), .rx_word_o(rword),
    .rx_word_valid_o(rv), .dev_status_o(dst), .dev_len_o(dln),
    .attention_o(attn));
  hsmp_checker hsmp_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .host_serial_clock(link_a.host_serial_clock),
    .host_slave_select_n(link_a.host_slave_select_n),
    .host_serial_in(link_a.host_serial_in),
    .host_serial_out(link_a.host_serial_out),
    .host_serial_out_oe(link_a.host_serial_out_oe),
    .host_attention(link_a.host_attention));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      chk("wb ack", 32'h1, 32'h0);
      test_done();
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e,
                    input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic till_attn(input logic v);
    int k;
    k = 0;
    while (attn !== v && k < 200) begin
      @(posedge clk_i);
      k++;
    end
    chk("attention", {31'h0, v}, {31'h0, attn});
  endtask
  task automatic frame(input logic [7:0] n, input logic r);
    int k;
    logic seen;
    seen = 1'b0;
    @(posedge clk_i);
    start <= 1'b1;
    len <= n;
    rdy <= r;
    @(posedge clk_i);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (done === 1'b1) seen = 1'b1;
    end while (busy !== 1'b0 && k < 4000);
    chk("frame done", 32'h1, {31'h0, seen});
    if (busy !== 1'b0) begin
      chk("frame busy", 32'h0, {31'h0, busy});
      test_done();
    end
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS, 32'h0, "status");
    rd(10'h3FC, 32'h0, "unmapped");
    wb(1'b1, 10'h180, 32'h00000001);
    wb(1'b1, 10'h184, 32'h5A5AA5A5);
    wb(1'b1, REG_CTRL, 32'h2);
    wb(1'b1, REG_TXCMD, 32'h102);
    till_attn(1'b1);
    wb(1'b1, REG_RXCMD, 32'h1);
    rd(REG_STATUS, 32'h3, "status");
    frame(8'h02, 1'b1);
    chk("dev status", 32'h3, {24'h0, dst});
    chk("dev length", 32'h2, {24'h0, dln});
    chk("rx word 0", 32'h00000001, rw[0]);
    chk("rx word 1", 32'h5A5AA5A5, rw[1]);
    rd(10'h100, 32'h00000001, "buffer 0");
    rd(10'h104, 32'hC3C33C3C, "buffer 1");
    rd(REG_STATUS, 32'h20C, "status");
    chk("irq", 32'h1, {31'h0, irq});
    chk("attention", 32'h0, {31'h0, attn});
    wb(1'b1, REG_STATUS, 32'h4);
    @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    frame(8'h01, 1'b0);
    chk("dev status", 32'h0, {24'h0, dst});
    chk("dev length", 32'h0, {24'h0, dln});
    wb(1'b1, REG_RXCMD, 32'h1);
    till_attn(1'b1);
    test_done();
  end
endmodule // test_host_spi_slave_message_port
